/* File: design/idpm_pkg.sv */
// Package of constants, register map and state codes for the idle-domain power manager.
// Contract
// - Idled clock generator output stops, held high
// - Readable status shows currently idled domains
// - Configuration applies only at next idle instruction; the code also applies it on a CTRL write with IDPM_CTRL_IDLE_GO set
// - Analog USB PLL never idles; software switches first
// - Core and USB generators idle independently
// - One generator idled keeps oscillator running
// - Emulator connected refuses idle entry
// - Four wake events restart the oscillator
// - Wake masks all external interrupts
// - Unmask timed by USB digital PLL
// - Wake restores only clock and CPU domains
// - Wrapper switches to PLL clock after lock
// - Idle stops CPU, DMA, memory port domains
// - Disabled domain retains memory, resumes when enabled
package idpm_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] IDPM_ADDR_CONFIG = 8'h00;
    localparam logic [7:0] IDPM_ADDR_STATE = 8'h04;
    localparam logic [7:0] IDPM_ADDR_CTRL = 8'h08;
    localparam logic [7:0] IDPM_ADDR_STATUS = 8'h0C;
    // -----------------------------------------------------------------
    // Domain bit positions
    // -----------------------------------------------------------------
    localparam int IDPM_NDOM = 6;
    localparam int IDPM_DOM_CPU = 0;
    localparam int IDPM_DOM_DMA = 1;
    localparam int IDPM_DOM_PERIPH = 2;
    localparam int IDPM_DOM_EMP = 3;
    localparam int IDPM_DOM_CORE_GEN = 4;
    localparam int IDPM_DOM_USB_GEN = 5;
    localparam logic [5:0] IDPM_CONFIG_RESET = 6'h00;
    localparam logic [5:0] IDPM_WAKE_KEEP = 6'h0E;
    // -----------------------------------------------------------------
    // Control and status bits
    // -----------------------------------------------------------------
    localparam int IDPM_CTRL_IDLE_EN = 0;
    localparam int IDPM_CTRL_IDLE_GO = 1;
    localparam int IDPM_CTRL_DPLL_OK = 2;
    localparam int IDPM_STAT_OSC_ON = 0;
    localparam int IDPM_STAT_IRQ_MASK = 1;
    localparam int IDPM_STAT_PLL_SEL = 2;
    localparam int IDPM_STAT_EMU_REF = 3;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int IDPM_CLK_MHZ = 200;
    localparam int IDPM_LOCK_WAIT_US = 1000;
    localparam int IDPM_LOCK_WAIT_CYC = IDPM_LOCK_WAIT_US * IDPM_CLK_MHZ;
    localparam int IDPM_UNMASK_DEF_CYC = 1024;
    typedef enum logic [3:0] {
        IDPM_RUN = 4'b0001,
        IDPM_IDLE = 4'b0010,
        IDPM_OSC_OFF = 4'b0100,
        IDPM_WAKE = 4'b1000
    } idpm_state_t;
endpackage

/* File: design/idpm_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module idpm_sync (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // The first stage is read only by the second; a change counts once stages two and three agree.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                o_level <= s3_q;
            end
        end
    end
endmodule

/* File: design/idpm_power_manager.sv */
// Idle-domain power manager: Wishbone registers, idle sequencing, oscillator and wake control.
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ps
module idpm_power_manager
    import idpm_pkg::*;
#(
    parameter int LOCK_WAIT_CYC = IDPM_LOCK_WAIT_CYC,
    parameter int UNMASK_CYC = IDPM_UNMASK_DEF_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_idle_instr,
    input wire logic i_emu_connected,
    input wire logic i_usb_wake,
    input wire logic i_rtc_irq,
    input wire logic i_ext_irq,
    input wire logic i_pll_lock,
    input wire logic i_core_gen_clk,
    input wire logic i_usb_gen_clk,
    output logic o_core_clk,
    output logic o_usb_clk,
    output logic [5:0] o_domain_idle,
    output logic o_osc_enable,
    output logic o_ext_irq_mask,
    output logic o_pll_clk_sel
);
    // -----------------------------------------------------------------
    // Parameter checks
    // -----------------------------------------------------------------
    if (LOCK_WAIT_CYC < 1 || UNMASK_CYC < 1) begin : g_bad_param
        $error("idpm_power_manager: wait counts must be at least one");
    end

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [4:0] raw_pins;
    logic [4:0] sync_pins;
    assign raw_pins = {i_pll_lock, i_ext_irq, i_rtc_irq, i_usb_wake, i_emu_connected};
    for (genvar g = 0; g < 5; g++) begin : g_sync
        idpm_sync u_sync (
            .i_ref_clk(i_ref_clk),
            .i_rst(i_rst),
            .i_async(raw_pins[g]),
            .o_level(sync_pins[g])
        );
    end
    logic emu_s;
    logic usb_wake_s;
    logic rtc_s;
    logic ext_s;
    logic lock_s;
    assign emu_s = sync_pins[0];
    assign usb_wake_s = sync_pins[1];
    assign rtc_s = sync_pins[2];
    assign ext_s = sync_pins[3];
    assign lock_s = sync_pins[4];

    // -----------------------------------------------------------------
    // Register bus
    // -----------------------------------------------------------------
    logic [5:0] idle_config_reg_q;
    logic [5:0] idle_state_reg_q;
    logic idle_enable_bit_q;
    logic dpll_ok_q;
    logic sw_idle_go;
    logic emu_refused_q;
    logic ext_mask_q;
    logic pll_sel_q;
    logic osc_on;
    logic wb_req;
    logic wb_wr;

    function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction

    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_req;
            if (wb_req && !i_wb_we) begin
                // Unmapped addresses read as zero and are still acknowledged.
                if (addr_is(i_wb_adr, IDPM_ADDR_CONFIG)) begin
                    o_wb_dat <= {26'h0, idle_config_reg_q};
                end else if (addr_is(i_wb_adr, IDPM_ADDR_STATE)) begin
                    o_wb_dat <= {26'h0, idle_state_reg_q};
                end else if (addr_is(i_wb_adr, IDPM_ADDR_CTRL)) begin
                    o_wb_dat <= {29'h0, dpll_ok_q, 1'b0, idle_enable_bit_q};
                end else if (addr_is(i_wb_adr, IDPM_ADDR_STATUS)) begin
                    o_wb_dat <= {28'h0, emu_refused_q, pll_sel_q, ext_mask_q, osc_on};
                end else begin
                    o_wb_dat <= 32'h0000_0000;
                end
            end
        end
    end

    // Storing the configuration never touches the live domain state.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            idle_config_reg_q <= IDPM_CONFIG_RESET;
        end else if (wb_wr && addr_is(i_wb_adr, IDPM_ADDR_CONFIG)) begin
            idle_config_reg_q <= i_wb_dat[5:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            idle_enable_bit_q <= 1'b0;
            dpll_ok_q <= 1'b0;
        end else if (wb_wr && addr_is(i_wb_adr, IDPM_ADDR_CTRL)) begin
            idle_enable_bit_q <= i_wb_dat[IDPM_CTRL_IDLE_EN];
            dpll_ok_q <= i_wb_dat[IDPM_CTRL_DPLL_OK];
        end
    end
    assign sw_idle_go = wb_wr && addr_is(i_wb_adr, IDPM_ADDR_CTRL)
        && i_wb_dat[IDPM_CTRL_IDLE_GO];

    // -----------------------------------------------------------------
    // Idle sequencer
    // -----------------------------------------------------------------
    idpm_state_t state_q;
    logic idle_req;
    logic wake_evt;
    logic both_gen;
    logic [5:0] apply_cfg;

    assign idle_req = i_idle_instr || sw_idle_go;
    // Hardware reset is the fourth wake source and is served by i_rst itself.
    assign wake_evt = usb_wake_s || rtc_s || ext_s;
    assign apply_cfg = idle_enable_bit_q ? idle_config_reg_q : 6'h00;
    assign both_gen = apply_cfg[IDPM_DOM_CORE_GEN] && apply_cfg[IDPM_DOM_USB_GEN];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= IDPM_RUN;
            idle_state_reg_q <= IDPM_CONFIG_RESET;
            emu_refused_q <= 1'b0;
        end else begin
            unique case (state_q)
                IDPM_RUN: begin
                    if (idle_req && emu_s) begin
                        emu_refused_q <= 1'b1;
                    end else if (idle_req) begin
                        emu_refused_q <= 1'b0;
                        // The config chooses domains; bits clear there resume at once.
                        idle_state_reg_q <= apply_cfg;
                        if (apply_cfg[IDPM_DOM_CPU]) begin
                            state_q <= both_gen ? IDPM_OSC_OFF : IDPM_IDLE;
                        end
                    end
                end
                IDPM_IDLE: begin
                    if (wake_evt) begin
                        idle_state_reg_q <= idle_state_reg_q & IDPM_WAKE_KEEP;
                        state_q <= IDPM_WAKE;
                    end
                end
                IDPM_OSC_OFF: begin
                    if (wake_evt) begin
                        idle_state_reg_q <= idle_state_reg_q & IDPM_WAKE_KEEP;
                        state_q <= IDPM_WAKE;
                    end
                end
                IDPM_WAKE: begin
                    state_q <= IDPM_RUN;
                end
                default: begin
                    state_q <= IDPM_RUN;
                end
            endcase
        end
    end

    // Oscillator comes back in the same cycle the wake event is seen.
    assign osc_on = !(state_q == IDPM_OSC_OFF && !wake_evt);
    assign o_osc_enable = osc_on;
    assign o_domain_idle = idle_state_reg_q;

    // -----------------------------------------------------------------
    // Clock gating
    // -----------------------------------------------------------------
    // Each generator is gated by its own bit only, so the other keeps running.
    assign o_core_clk = i_core_gen_clk | idle_state_reg_q[IDPM_DOM_CORE_GEN];
    assign o_usb_clk = i_usb_gen_clk | idle_state_reg_q[IDPM_DOM_USB_GEN];

    // -----------------------------------------------------------------
    // External interrupt mask after wake
    // -----------------------------------------------------------------
    logic [31:0] unmask_cnt_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ext_mask_q <= 1'b0;
            unmask_cnt_q <= 32'h0000_0000;
        end else if (state_q == IDPM_WAKE) begin
            ext_mask_q <= 1'b1;
            unmask_cnt_q <= 32'h0000_0000;
        end else if (ext_mask_q && dpll_ok_q) begin
            // Without a configured USB digital PLL the mask stays set.
            if (unmask_cnt_q >= 32'(UNMASK_CYC - 1)) begin
                ext_mask_q <= 1'b0;
            end else begin
                unmask_cnt_q <= unmask_cnt_q + 32'h0000_0001;
            end
        end
    end
    assign o_ext_irq_mask = ext_mask_q;

    // -----------------------------------------------------------------
    // PLL wrapper select
    // -----------------------------------------------------------------
    logic [31:0] lock_cnt_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pll_sel_q <= 1'b0;
            lock_cnt_q <= 32'h0000_0000;
        end else if (!lock_s || state_q == IDPM_OSC_OFF) begin
            pll_sel_q <= 1'b0;
            lock_cnt_q <= 32'h0000_0000;
        end else if (!pll_sel_q) begin
            // Bypass clock is kept until the lock has been stable for the full wait.
            if (lock_cnt_q >= 32'(LOCK_WAIT_CYC - 1)) begin
                pll_sel_q <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 32'h0000_0001;
            end
        end
    end
    assign o_pll_clk_sel = pll_sel_q;
endmodule

/* File: tb/idpm_checker.sv */
// Port-level assertion checker for the idle-domain power manager.
`timescale 1ns/1ps
module idpm_checker
    import idpm_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_idle_instr,
    input wire logic i_emu_connected,
    input wire logic i_usb_wake,
    input wire logic i_rtc_irq,
    input wire logic i_ext_irq,
    input wire logic i_pll_lock,
    input wire logic i_core_gen_clk,
    input wire logic i_usb_gen_clk,
    input logic o_wb_ack,
    input logic o_core_clk,
    input logic o_usb_clk,
    input logic [5:0] o_domain_idle,
    input logic o_osc_enable,
    input logic o_ext_irq_mask,
    input logic o_pll_clk_sel
);
    // ---------
    // Properties
    // ---------
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_core_held: assert property (o_domain_idle[4] |-> o_core_clk)
        else $error("core clock not held high");
    a_usb_held: assert property (o_domain_idle[5] |-> o_usb_clk)
        else $error("usb clock not held high");
    a_gen_indep: assert property (o_domain_idle[5:4] == 2'b10 |-> o_core_clk == i_core_gen_clk)
        else $error("core clock stopped by usb idle");
    a_usb_indep: assert property (o_domain_idle[5:4] == 2'b01 |-> o_usb_clk == i_usb_gen_clk)
        else $error("usb clock stopped by core idle");
    a_osc_one_gen: assert property (^o_domain_idle[5:4] |-> o_osc_enable)
        else $error("oscillator off with one generator idled");
    a_osc_off_both: assert property (!o_osc_enable |-> &o_domain_idle[5:4])
        else $error("oscillator off without both generators idled");
    a_emu_refuse: assert property (i_emu_connected[*6] ##1 i_idle_instr |=> $stable(o_domain_idle))
        else $error("idle entered with emulator attached");
    a_wake_osc: assert property (!o_osc_enable && (i_usb_wake | i_rtc_irq | i_ext_irq)
        |-> ##[0:6] o_osc_enable)
        else $error("oscillator not restarted by wake");
    a_wake_keep: assert property ($fell(o_domain_idle[0]) |-> (o_domain_idle & 6'h31) == 6'h00)
        else $error("wake left clock or cpu domain idled");
    a_wake_mask: assert property ($fell(o_domain_idle[0]) |-> ##[0:2] o_ext_irq_mask)
        else $error("external interrupts not masked at wake");
    a_pll_lock: assert property ($rose(o_pll_clk_sel) |-> i_pll_lock)
        else $error("pll clock selected without lock");
    a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus ack late");
    a_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus ack longer than one cycle");
    cover property (!o_osc_enable);
    cover property ($fell(o_domain_idle[0]));
    cover property ($rose(o_pll_clk_sel));
endmodule
bind idpm_power_manager idpm_checker u_chk (.i_ref_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
    .i_idle_instr, .i_emu_connected, .i_usb_wake, .i_rtc_irq, .i_ext_irq, .i_pll_lock,
    .i_core_gen_clk, .i_usb_gen_clk, .o_wb_ack, .o_core_clk, .o_usb_clk, .o_domain_idle,
    .o_osc_enable,
    .o_ext_irq_mask, .o_pll_clk_sel);

/* File: tb/idpm_wake_partner.sv */
// Wake sources and clock generators on the far side of the power manager.
`timescale 1ns/1ps
module idpm_wake_partner #(
    parameter int SETTLE = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_fire,
    input wire logic [1:0] i_kind,
    output logic o_usb_wake,
    output logic o_rtc_irq,
    output logic o_ext_irq,
    output logic o_core_gen_clk,
    output logic o_usb_gen_clk
);
    int hold_q = 0;
    logic [1:0] kind_q = 2'h0;
    initial {o_usb_wake, o_rtc_irq, o_ext_irq, o_core_gen_clk, o_usb_gen_clk} = 5'h00;
    // A wake event is held ten cycles plus the oscillator settling time.
    always @(posedge i_ref_clk) begin
        if (i_fire) begin
            hold_q <= 10 + SETTLE;
            kind_q <= i_kind;
        end else if (hold_q > 0) begin
            hold_q <= hold_q - 1;
        end
        o_usb_wake <= (i_fire && i_kind == 2'h0) || (hold_q > 1 && kind_q == 2'h0);
        o_rtc_irq <= (i_fire && i_kind == 2'h1) || (hold_q > 1 && kind_q == 2'h1);
        o_ext_irq <= (i_fire && i_kind == 2'h2) || (hold_q > 1 && kind_q == 2'h2);
        o_core_gen_clk <= ~o_core_gen_clk;
        o_usb_gen_clk <= ~o_usb_gen_clk;
    end
endmodule

/* File: tb/idpm_power_manager_bench.sv */
// Self-checking bench for the idle-domain power manager.
`timescale 1ns/1ps
module idpm_power_manager_bench;
    import idpm_pkg::*;
    localparam int UNM = 8;
    logic i_ref_clk = 0, i_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
    logic [3:0] i_wb_sel = 4'hF;
    logic i_idle_instr = 0, i_emu_connected = 0, i_pll_lock = 0, fire = 0;
    logic [1:0] kind = 2'h0;
    logic i_usb_wake, i_rtc_irq, i_ext_irq, i_core_gen_clk, i_usb_gen_clk, o_wb_ack;
    logic o_core_clk, o_usb_clk, o_osc_enable, o_ext_irq_mask, o_pll_clk_sel;
    logic [5:0] o_domain_idle;
    int miscompares = 0, comparisons = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    idpm_power_manager #(.LOCK_WAIT_CYC(20), .UNMASK_CYC(UNM)) dut (.*);
    idpm_wake_partner part (.i_ref_clk, .i_fire(fire), .i_kind(kind), .o_usb_wake(i_usb_wake),
        .o_rtc_irq(i_rtc_irq), .o_ext_irq(i_ext_irq), .o_core_gen_clk(i_core_gen_clk),
        .o_usb_gen_clk(i_usb_gen_clk));
    // ---------
    // Tasks
    // ---------
    task automatic summarize();
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Read data and ack are sampled with their values from just before the edge.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_ref_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, a, d};
        for (n = 0; n < 16; n++) begin
            @(posedge i_ref_clk);
            if (o_wb_ack === 1'b1) break;
        end
        q = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'b00;
        if (n == 16) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic wt(input logic pll);
        int n;
        for (n = 0; n < 64 && (pll ? o_pll_clk_sel : o_osc_enable) !== 1'b1; n++) cyc(1);
        if (n == 64) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic rst_dut();
        @(posedge i_ref_clk) i_rst <= 1;
        cyc(6);
        i_rst <= 0;
    endtask
    task automatic go_idle(input logic [5:0] cfg, input logic [31:0] ctl);
        logic [5:0] held;
        held = o_domain_idle;
        wb(1, IDPM_ADDR_CONFIG, {26'h0, cfg});
        wb(1, IDPM_ADDR_CTRL, ctl);
        cyc(1);
        chk(o_domain_idle, held);
        cyc(6);
        i_idle_instr <= 1;
        @(posedge i_ref_clk) i_idle_instr <= 0;
        #1;
    endtask
    // ---------
    // Scenarios
    // ---------
    initial begin
        rst_dut();
        wb(0, IDPM_ADDR_STATUS, 0);
        chk(q, 32'h1);
        wb(1, 8'h10, 32'hFFFFFFFF);
        wb(0, 8'h10, 0);
        chk(q, 32'h0);
        wb(1, IDPM_ADDR_CONFIG, 32'hFFFFFFFF);
        wb(0, IDPM_ADDR_CONFIG, 0);
        chk(q, 32'h3F);
        wb(1, IDPM_ADDR_CTRL, 32'h7);
        wb(0, IDPM_ADDR_CTRL, 0);
        chk(q, 32'h5);
        chk(o_domain_idle, 6'h00);
        for (int k = 0; k < 4; k++) begin
            rst_dut();
            go_idle(6'h3F, (k < 3) ? 32'h5 : 32'h1);
            chk(o_osc_enable, 1'b0);
            chk({o_core_clk, o_usb_clk}, 2'b11);
            wb(0, IDPM_ADDR_STATE, 0);
            chk(q, 32'h3F);
            fire <= 1;
            kind <= k[1:0] % 2'h3;
            @(posedge i_ref_clk) fire <= 0;
            wt(0);
            cyc(4);
            chk(o_domain_idle, 6'h0E);
            chk(o_ext_irq_mask, 1'b1);
            wb(0, IDPM_ADDR_STATUS, 0);
            chk(q, 32'h3);
            cyc(UNM + 40);
            chk(o_ext_irq_mask, k == 3);
            go_idle(6'h00, 32'h0);
            chk(o_domain_idle, 6'h00);
        end
        rst_dut();
        go_idle(6'h3F, 32'h5);
        rst_dut();
        chk({o_osc_enable, o_domain_idle}, 7'h40);
        go_idle(6'h11, 32'h5);
        chk(o_osc_enable, 1'b1);
        chk(o_usb_clk, i_usb_gen_clk);
        chk(o_core_clk, 1'b1);
        rst_dut();
        go_idle(6'h21, 32'h5);
        chk(o_osc_enable, 1'b1);
        chk(o_core_clk, i_core_gen_clk);
        chk(o_usb_clk, 1'b1);
        rst_dut();
        i_emu_connected <= 1;
        cyc(8);
        go_idle(6'h3F, 32'h5);
        chk(o_domain_idle, 6'h00);
        wb(0, IDPM_ADDR_STATUS, 0);
        chk(q[3], 1'b1);
        i_emu_connected <= 0;
        rst_dut();
        i_pll_lock <= 1;
        cyc(16);
        chk(o_pll_clk_sel, 1'b0);
        wt(1);
        summarize();
    end
endmodule
